//--- logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int RES_W  = 12;

  // Register byte addresses, one 32-bit word each
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_INPUT_CLOCK = 8'h0c;
  localparam logic [7:0] ADDR_REF_GAIN    = 8'h10;
  localparam logic [7:0] ADDR_BANDGAP     = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1c;

  // Main control fields
  localparam int MC_START   = 7;
  localparam int MC_BUSY    = 6;
  localparam int MC_ENABLE  = 5;
  localparam int MC_JUSTIFY = 4;

  // Writable bit masks; other bits read as zero, except main control bit 6, which reads busy
  localparam logic [7:0] MAIN_WR_MASK  = 8'hbf;
  localparam logic [7:0] INCLK_WR_MASK = 8'hf7;
  localparam logic [7:0] REFG_WR_MASK  = 8'h9f;
  localparam logic [7:0] BG_WR_MASK    = 8'h01;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Interrupt status bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_W       = 2;

  // Channel codes
  localparam logic [3:0] CH_LAST_LOW = 4'h8;
  localparam logic [3:0] CH_RESERVED = 4'h9;

  // Cycles the comparator needs after a trial code change
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'h0,
    SRC_SUPPLY_1 = 3'h1,
    SRC_SUPPLY_2 = 3'h2,
    SRC_SUPPLY_4 = 3'h3,
    SRC_AMP_1    = 3'h4,
    SRC_AMP_2    = 3'h5,
    SRC_AMP_4    = 3'h6,
    SRC_GROUND   = 3'h7
  } source_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_DONE    = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic       conv_power;
    logic       ext_path_en;
    logic [3:0] ext_channel;
    source_t    source;
    logic       bandgap_enable;
    logic       gain_amp_enable;
    logic       gain_amp_input_select;
    logic [1:0] reference_select;
    logic [1:0] gain_select;
  } analog_ctrl_t;

endpackage : adc_ctrl_pkg

//--- logic/adc_control_and_result.sv
// Functional notes
// R1: Each conversion yields a 12-bit unsigned value held in two read-only bytes.
// R2: Justify 0: bits 11..4 in high byte, bits 3..0 in low upper nibble.
// R3: Justify 1: bits 11..8 in high lower nibble, bits 7..0 in low byte.
// R4: Result bits unused by the chosen justification read as zero.
// R5: With converter disabled, result registers keep their previous contents.
// R6: Writing start high then low launches exactly one conversion.
// R7: Busy rises when the start pulse completes, clears when result is ready.
// R8: Busy is read-only; writes to its position have no effect.
// R9: Enable bit must be set to convert; clearing it powers the converter down.
// R10: Channel codes 0-8, 10, 11 select inputs; 1001 reserved; 11xx floating.
// R11: Converted signal depends on internal select and external channel fields.
// R12: Any internal source selection disconnects the external channel path.
// R13: Software configures pin sharing for analog before selecting a channel.
// R14: A pin assigned as converter input loses its I/O and shared functions.
// R15: A pin assigned as converter input has its pull-high removed.
// R16: A separate one-bit register enables the bandgap reference.
// R17: Internal select maps to external, supply/1/2/4, amp/1/2/4, or ground.
// R18: Clock field codes 0..7 divide the system clock by 1..128.
// R19: Both result bytes update together at the end of a conversion.
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

module adc_control_and_result #(
  parameter int PINS = 12
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           irq_o,
  input  wire logic                      comp_i,
  output logic [adc_ctrl_pkg::RES_W-1:0] dac_code_o,
  output logic                           sample_o,
  output adc_ctrl_pkg::analog_ctrl_t     analog_ctrl_o,
  input  wire logic [PINS-1:0]           pin_analog_sel_i,
  output logic [PINS-1:0]                pin_func_remove_o,
  output logic [PINS-1:0]                pullup_remove_o
);
  import adc_ctrl_pkg::*;

  logic [7:0]       main_control_reg;
  logic [7:0]       input_clock_reg;
  logic [7:0]       reference_gain_reg;
  logic [7:0]       bandgap_ctrl_reg;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] trial;
  logic [3:0]       bit_idx;
  logic [1:0]       settle;
  logic [6:0]       div_cnt;
  logic             conversion_busy;
  logic             start_seen;
  logic             comp_meta;
  logic             comp_sync;
  conv_state_t      state;

  logic             converter_enable;
  logic             result_justify;
  logic [3:0]       external_channel_select;
  logic [3:0]       internal_signal_select;
  logic [2:0]       conversion_clock_select;
  logic             wr_req;
  logic             rd_req;
  logic             wr_main;
  logic             wr_byte;
  logic             launch;
  logic             ignored;
  logic             done_evt;
  logic             div_tick;
  logic [6:0]       div_mask;
  logic [7:0]       result_low_byte;
  logic [7:0]       result_high_byte;
  logic [7:0]       next_rdata;
  source_t          next_source;
  logic             next_ext_en;

  assign converter_enable        = main_control_reg[MC_ENABLE];
  assign result_justify          = main_control_reg[MC_JUSTIFY];
  assign external_channel_select = main_control_reg[3:0];
  assign internal_signal_select  = input_clock_reg[7:4];
  assign conversion_clock_select = input_clock_reg[2:0];

  // Bus handshake: one wait state, writes land at the edge that sees ack high
  assign wr_req  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign rd_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign wr_byte = wr_req && wb_sel_i[0];
  assign wr_main = wr_byte && (wb_adr_i == ADDR_MAIN_CTRL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Start detection: high then low on the stored start bit
  assign launch  = wr_main && start_seen && !wb_dat_i[MC_START]
                   && converter_enable && wb_dat_i[MC_ENABLE]
                   && !conversion_busy;                       // see R6 see R9
  assign ignored = wr_main && start_seen && !wb_dat_i[MC_START] && !launch;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_seen <= 1'b0;
    end else if (wr_main) begin
      start_seen <= wb_dat_i[MC_START];                       // see R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_control_reg   <= REG_RESET;
      input_clock_reg    <= REG_RESET;
      reference_gain_reg <= REG_RESET;
      bandgap_ctrl_reg   <= REG_RESET;
      irq_mask           <= '0;
    end else if (wr_byte) begin
      case (wb_adr_i)
        ADDR_MAIN_CTRL: begin
          main_control_reg <= wb_dat_i[7:0] & MAIN_WR_MASK;   // see R8
        end
        ADDR_INPUT_CLOCK: begin
          input_clock_reg <= wb_dat_i[7:0] & INCLK_WR_MASK;
        end
        ADDR_REF_GAIN: begin
          reference_gain_reg <= wb_dat_i[7:0] & REFG_WR_MASK;
        end
        ADDR_BANDGAP: begin
          bandgap_ctrl_reg <= wb_dat_i[7:0] & BG_WR_MASK;     // see R16
        end
        ADDR_IRQ_MASK: begin
          irq_mask <= wb_dat_i[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Conversion clock enable: divide by 2**select
  assign div_mask = 7'((8'h01 << conversion_clock_select) - 8'h01);
  assign div_tick = (div_cnt & div_mask) == div_mask;         // see R18

  always_ff @(posedge clk_i) begin
    if (rst_i || !converter_enable) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_i;
      comp_sync <= comp_meta;
    end
  end

  // Successive approximation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i || !converter_enable) begin
      state           <= ST_IDLE;
      conversion_busy <= 1'b0;
      trial           <= '0;
      bit_idx         <= '0;
      settle          <= '0;
      sample_o        <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            state           <= ST_SAMPLE;
            conversion_busy <= 1'b1;                          // see R7
            sample_o        <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (div_tick) begin
            state    <= ST_CONVERT;
            sample_o <= 1'b0;
            trial    <= RES_W'(1) << (RES_W - 1);
            bit_idx  <= 4'(RES_W - 1);
            settle   <= '0;
          end
        end
        ST_CONVERT: begin
          if (settle != SETTLE_CYCLES) begin
            settle <= settle + 2'h1;
          end else if (div_tick) begin
            settle <= '0;
            if (!comp_sync) begin
              trial[bit_idx] <= 1'b0;
            end
            if (bit_idx == 4'h0) begin
              state <= ST_DONE;
            end else begin
              trial[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        ST_DONE: begin
          state           <= ST_IDLE;
          conversion_busy <= 1'b0;                            // see R7
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign done_evt = (state == ST_DONE) && converter_enable;

  // Single 12-bit store, so both bytes change in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (done_evt) begin
      result <= trial;                                        // see R1 see R19 see R5
    end
  end

  always_comb begin
    if (result_justify) begin
      result_high_byte = {4'h0, result[11:8]};                // see R3 see R4
      result_low_byte  = result[7:0];                         // see R3
    end else begin
      result_high_byte = result[11:4];                        // see R2
      result_low_byte  = {result[3:0], 4'h0};                 // see R2 see R4
    end
  end

  always_comb begin
    case (wb_adr_i)
      ADDR_RESULT_LOW:  next_rdata = result_low_byte;
      ADDR_RESULT_HIGH: next_rdata = result_high_byte;
      ADDR_MAIN_CTRL: begin
        next_rdata = main_control_reg;
        next_rdata[MC_BUSY] = conversion_busy;                // see R8
      end
      ADDR_INPUT_CLOCK: next_rdata = input_clock_reg;
      ADDR_REF_GAIN:    next_rdata = reference_gain_reg;
      ADDR_BANDGAP:     next_rdata = bandgap_ctrl_reg;
      ADDR_IRQ_STATUS:  next_rdata = {6'h00, irq_status};
      ADDR_IRQ_MASK:    next_rdata = {6'h00, irq_mask};
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_req) begin
      wb_dat_o <= {24'h000000, next_rdata};
    end
  end

  // Sticky events: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE && done_evt) || (i == IRQ_IGNORED && ignored)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_byte && wb_adr_i == ADDR_IRQ_STATUS && wb_dat_i[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Input source decode
  always_comb begin
    case (internal_signal_select)
      4'h1:    next_source = SRC_SUPPLY_1;                    // see R17
      4'h2:    next_source = SRC_SUPPLY_2;
      4'h3:    next_source = SRC_SUPPLY_4;
      4'h5:    next_source = SRC_AMP_1;
      4'h6:    next_source = SRC_AMP_2;
      4'h7:    next_source = SRC_AMP_4;
      4'h8, 4'h9, 4'ha, 4'hb: next_source = SRC_GROUND;
      default: next_source = SRC_EXTERNAL;
    endcase
    next_ext_en = (next_source == SRC_EXTERNAL)               // see R11 see R12
                  && (external_channel_select <= CH_LAST_LOW
                      || (external_channel_select > CH_RESERVED
                          && external_channel_select[3:2] != 2'b11)); // see R10
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_ctrl_o <= '0;
      dac_code_o    <= '0;
    end else begin
      analog_ctrl_o.conv_power            <= converter_enable;      // see R9
      analog_ctrl_o.ext_path_en           <= next_ext_en && converter_enable;
      analog_ctrl_o.ext_channel           <= external_channel_select;
      analog_ctrl_o.source                <= next_source;
      analog_ctrl_o.bandgap_enable        <= bandgap_ctrl_reg[0];    // see R16
      analog_ctrl_o.gain_amp_enable       <= reference_gain_reg[7];
      analog_ctrl_o.gain_amp_input_select <= reference_gain_reg[4];
      analog_ctrl_o.reference_select      <= reference_gain_reg[3:2];
      analog_ctrl_o.gain_select           <= reference_gain_reg[1:0];
      dac_code_o                          <= trial;
    end
  end

  // Pins taken for analog use lose digital function and pull-high
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_func_remove_o[p] <= 1'b0;
        pullup_remove_o[p]   <= 1'b0;
      end else begin
        pin_func_remove_o[p] <= pin_analog_sel_i[p];          // see R14
        pullup_remove_o[p]   <= pin_analog_sel_i[p];          // see R15
      end
    end
  end

endmodule : adc_control_and_result

`default_nettype wire

//--- testbench/adc_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_monitor #(
  parameter int PINS = 12
) (
  input wire logic                           clk_i,
  input wire logic                           rst_i,
  input wire logic                           wb_cyc_i,
  input wire logic                           wb_stb_i,
  input wire logic [31:0]                    wb_dat_o,
  input wire logic                           wb_ack_o,
  input wire logic                           sample_o,
  input wire logic [adc_ctrl_pkg::RES_W-1:0] dac_code_o,
  input wire adc_ctrl_pkg::analog_ctrl_t     analog_ctrl_o,
  input wire logic [PINS-1:0]                pin_analog_sel_i,
  input wire logic [PINS-1:0]                pin_func_remove_o,
  input wire logic [PINS-1:0]                pullup_remove_o
);
  import adc_ctrl_pkg::*;
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack lasted more than one cycle");
  ack_follows_request_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  pin_copy_a: assert property (
    !$past(rst_i) |-> pin_func_remove_o == $past(pin_analog_sel_i)
    && pullup_remove_o == $past(pin_analog_sel_i))
    else $error("pin removal does not follow analog selection");
  ext_path_a: assert property (
    analog_ctrl_o.ext_path_en |-> analog_ctrl_o.source == SRC_EXTERNAL
    && analog_ctrl_o.ext_channel != CH_RESERVED && analog_ctrl_o.ext_channel[3:2] != 2'h3)
    else $error("external path connected while not allowed");
  sample_power_a: assert property (sample_o |-> analog_ctrl_o.conv_power)
    else $error("sampling while converter off");
  first_trial_a: assert property (($fell(sample_o) && analog_ctrl_o.conv_power)
    |-> ##[0:1] dac_code_o == 12'h800)
    else $error("first trial code is not mid scale");
endmodule : adc_ctrl_monitor
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adc_ctrl_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1, comp_i = 1'b0;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]   wb_adr_i = 8'h0;
  logic [3:0]   wb_sel_i = 4'hf;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o;
  logic         wb_ack_o, irq_o, sample_o;
  logic [11:0]  dac_code_o, pin_func_remove_o, pullup_remove_o, rd, target = 12'h0;
  logic [11:0]  pin_analog_sel_i = 12'h0;
  analog_ctrl_t analog_ctrl_o;
  int           err_total = 0, checked = 0, n;
  logic [7:0]   adrs[5] = '{ADDR_INPUT_CLOCK, ADDR_REF_GAIN, ADDR_BANDGAP, ADDR_IRQ_MASK, 8'h20};
  logic [11:0]  masks[5] = '{12'h0f7, 12'h09f, 12'h001, 12'h003, 12'h000};

  adc_control_and_result u_adc_control_and_result (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .comp_i,
    .dac_code_o, .sample_o, .analog_ctrl_o, .pin_analog_sel_i, .pin_func_remove_o,
    .pullup_remove_o);

  initial forever #5 clk_i = ~clk_i;
  // Comparator follows the trial code within the same time step
  always @(dac_code_o or target) comp_i <= (target >= dac_code_o);

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      print_verdict();
    end
    rd = wb_dat_o[11:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic convert(input logic [7:0] cfg, input logic [11:0] tgt);
    target = tgt;
    bus(1'b1, ADDR_MAIN_CTRL, 8'ha0 | cfg);
    bus(1'b1, ADDR_MAIN_CTRL, 8'h20 | cfg);
    bus(1'b1, ADDR_MAIN_CTRL, 8'h60 | cfg);
    bus(1'b0, ADDR_MAIN_CTRL, 8'h0);
    chk("busy after start", rd, 12'h060 | 12'(cfg));
    n = 0;
    do begin
      bus(1'b0, ADDR_MAIN_CTRL, 8'h0);
      n += 3;
    end while (rd[MC_BUSY] === 1'b1 && n < 9000);
    chk("busy cleared", 12'(rd[MC_BUSY]), 12'h0);
  endtask : convert

  function automatic logic [2:0] exp_src(input int c);
    if (c >= 8 && c < 12) return 3'h7;
    if (c[1:0] == 2'h0 || c >= 12) return 3'h0;
    return (c < 4) ? 3'(c) : 3'(c - 1);
  endfunction : exp_src

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a <= 32; a += 4) begin
      bus(1'b0, 8'(a), 8'h0);
      chk("reset value", rd, 12'h0);
    end
    $display("test reset values done");
    bus(1'b1, ADDR_INPUT_CLOCK, 8'h00);
    convert(8'h03, 12'habc);
    chk("fast conversion length", 12'(n < 200), 12'h1);
    bus(1'b0, ADDR_RESULT_LOW, 8'h0);
    chk("low justify 0", rd, 12'h0c0);
    bus(1'b0, ADDR_RESULT_HIGH, 8'h0);
    chk("high justify 0", rd, 12'h0ab);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h0);
    chk("done status", rd, 12'h001);
    chk("irq masked", 12'(irq_o), 12'h0);
    bus(1'b1, ADDR_IRQ_MASK, 8'h03);
    @(posedge clk_i);
    chk("irq raised", 12'(irq_o), 12'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h01);
    @(posedge clk_i);
    chk("irq cleared", 12'(irq_o), 12'h0);
    $display("test first conversion done");
    bus(1'b1, ADDR_MAIN_CTRL, 8'h33);
    bus(1'b0, ADDR_RESULT_LOW, 8'h0);
    chk("low justify 1", rd, 12'h0bc);
    bus(1'b0, ADDR_RESULT_HIGH, 8'h0);
    chk("high justify 1", rd, 12'h00a);
    bus(1'b1, ADDR_MAIN_CTRL, 8'h13);
    @(posedge clk_i);
    chk("power off", 12'(analog_ctrl_o.conv_power), 12'h0);
    bus(1'b0, ADDR_RESULT_LOW, 8'h0);
    chk("low kept", rd, 12'h0bc);
    bus(1'b1, ADDR_MAIN_CTRL, 8'h90);
    bus(1'b1, ADDR_MAIN_CTRL, 8'h10);
    bus(1'b0, ADDR_MAIN_CTRL, 8'h0);
    chk("no start when off", rd, 12'h010);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h0);
    chk("start ignored flag", rd, 12'h002);
    chk("irq on ignored", 12'(irq_o), 12'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h02);
    $display("test format and disable done");
    bus(1'b1, ADDR_INPUT_CLOCK, 8'h07);
    convert(8'h0a, 12'h005);
    chk("slow conversion length", 12'(n >= 1536), 12'h1);
    bus(1'b0, ADDR_RESULT_LOW, 8'h0);
    chk("low slow", rd, 12'h050);
    bus(1'b0, ADDR_RESULT_HIGH, 8'h0);
    chk("high slow", rd, 12'h000);
    $display("test divided clock done");
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, ADDR_MAIN_CTRL, 8'h20 | 8'(i));
      bus(1'b1, ADDR_INPUT_CLOCK, 8'h00);
      @(posedge clk_i);
      chk("channel", 12'(analog_ctrl_o.ext_channel), 12'(i));
      chk("channel path", 12'(analog_ctrl_o.ext_path_en), 12'(i != 9 && i < 12));
      bus(1'b1, ADDR_MAIN_CTRL, 8'h22);
      bus(1'b1, ADDR_INPUT_CLOCK, 8'(i << 4));
      @(posedge clk_i);
      chk("source", 12'(analog_ctrl_o.source), 12'(exp_src(i)));
      chk("source path", 12'(analog_ctrl_o.ext_path_en), 12'(exp_src(i) == 3'h0));
    end
    $display("test input selection done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, adrs[i], 8'hff);
      bus(1'b0, adrs[i], 8'h0);
      chk("register mask", rd, masks[i]);
    end
    chk("bandgap on", 12'(analog_ctrl_o.bandgap_enable), 12'h1);
    chk("ref gain fields", 12'({analog_ctrl_o.gain_amp_enable, analog_ctrl_o.gain_amp_input_select,
      analog_ctrl_o.reference_select, analog_ctrl_o.gain_select}), 12'h03f);
    pin_analog_sel_i <= 12'ha5c;
    repeat (2) @(posedge clk_i);
    chk("pin function removed", pin_func_remove_o, 12'ha5c);
    chk("pull-high removed", pullup_remove_o, 12'ha5c);
    $display("test registers and pins done");
    print_verdict();
  end
endmodule : tb_top

bind adc_control_and_result adc_ctrl_monitor #(.PINS(PINS)) u_adc_ctrl_monitor (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sample_o, .dac_code_o, .analog_ctrl_o,
  .pin_analog_sel_i, .pin_func_remove_o, .pullup_remove_o);
`default_nettype wire
